// ---- baud_if.sv ----
// divisor and tick carrier between the status block and its rate generator
`timescale 1ns/1ns
interface baud_if;
	logic [15:0] divisor_int; // active integer divisor
	logic [5:0] divisor_frac; // active fractional divisor, 64ths
	logic tick; // one pulse per sixteenth of a bit
	modport gen (input divisor_int, input divisor_frac, output tick);
	modport user (output divisor_int, output divisor_frac, input tick);
endinterface

// ---- baud_tick_gen.sv ----
// fractional rate generator producing sixteen ticks per bit
`timescale 1ns/1ns
module baud_tick_gen
	import uart_status_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // synchronised reset, active low
	baud_if.gen baud // divisor in, tick out
);
	logic [ACC_W-1:0] acc; // phase in 64ths of a clock
	logic [ACC_W-1:0] div64; // divisor scaled to 64ths
	logic [ACC_W-1:0] next_acc; // phase after this clock

	// integer and fraction concatenate into the divisor times sixty-four
	assign div64 = {1'b0, baud.divisor_int, baud.divisor_frac};
	assign next_acc = acc + FRAC_ONE;

	////////////////////////////////////////////////////////////////////////
	// accumulate one clock per cycle, tick each time a divisor is passed
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= '0;
			baud.tick <= 1'b0;
		end else if (div64 == '0) begin // zero divisor: stopped
			acc <= '0;
			baud.tick <= 1'b0;
		end else if (next_acc >= div64) begin
			acc <= next_acc - div64;
			baud.tick <= 1'b1;
		end else begin
			acc <= next_acc;
			baud.tick <= 1'b0;
		end
	end
endmodule // baud_tick_gen

// ---- serial_peer_model.sv ----
// remote serial device driving whole frames onto the receive line
`timescale 1ns/1ns
module serial_peer_model (
	input wire logic clk_i, // bench clock
	output logic rxd_o // receive line, idle high
);
	localparam int BIT_CLKS = 16; // integer divisor one: sixteen clocks per bit
	initial rxd_o = 1'b1;
	// level held for whole bits, always changed just after an edge
	task automatic put_bit(input logic b, input int nbits);
		rxd_o <= b;
		repeat (nbits * BIT_CLKS) @(posedge clk_i);
	endtask
	// start, eight data bits lsb first, optional parity, stop, then idle
	task automatic send_frame(input logic [7:0] d, input logic use_par, input logic par,
		input logic stop);
		int i;
		@(posedge clk_i);
		put_bit(1'b0, 1);
		for (i = 0; i < 8; i++) begin
			put_bit(d[i], 1);
		end
		if (use_par) begin
			put_bit(par, 1);
		end
		put_bit(stop, 1);
		put_bit(1'b1, 2); // idle gap so the next start is clean
	endtask
	// line held low far past one frame, then released to mark
	task automatic hold_low(input int nbits);
		@(posedge clk_i);
		put_bit(1'b0, nbits);
		put_bit(1'b1, 2);
	endtask
endmodule // serial_peer_model

// ---- uart_status_flags.sv ----
// uart receive status, line flags and baud divisor block with apb access
// Function
// - break, parity, frame follow last read character
// - overrun flag rises when overrun occurs
// - overrun set on full, cleared on store
// - break when line low a frame
// - break loads one zero, waits for idle
// - parity error against even/stick selection
// - framing error when stop bit low
// - transmit empty ignores shifter, resets one
// - receive full per fifo or holding mode
// - transmit full per fifo or holding mode
// - receive empty per fifo or holding mode
// - busy from fifo non-empty through stop
// - clear-to-send bit inverts input pin
// - ring, carrier, data-set-ready read zero
// - infrared dummy ignores writes, reads zero
// - integer divisor sixteen bits, resets zero
// - fractional divisor six bits, resets zero
// - divisor gives sixteen ticks per bit
// - new divisor waits for character end
// - fifo enable off means one-entry holding
// - stick parity sends constant inverse of even
`timescale 1ns/1ns
module uart_status_flags
	import uart_status_pkg::*;
(
	input wire logic clk_sys_i, // 125 MHz system clock
	input wire logic reset_n_i, // asynchronous reset, active low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb access phase
	input wire logic pwrite_i, // apb direction, high writes
	input wire logic [11:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	input wire logic rxd_i, // serial receive line
	input wire logic clear_to_send_n_input_i, // clear to send, active low
	input wire logic fifo_enable_i, // one selects fifo mode
	input wire logic parity_enable_i, // one adds a parity bit
	input wire logic even_parity_select_i, // one selects even parity
	input wire logic stick_parity_select_i, // one forces constant parity
	input wire logic data_read_i, // pulse: data register read, pops rx
	input wire logic tx_write_i, // pulse: data register write, pushes tx
	input wire logic tx_pop_i, // pulse: shifter takes a tx character
	input wire logic tx_shift_busy_i, // shifter sending, stop bits too
	output logic [DATA_W-1:0] rx_data_o, // character popped by last read
	output logic rx_char_valid_o, // pulse: rx_data_o refreshed
	output logic rx_empty_o, // receive side holds nothing
	output logic tx_full_o // transmit side cannot take a character
);
	logic [1:0] rst_pipe; // reset release synchroniser
	logic rst_n; // synchronised reset for the block
	baud_if baud (); // rate generator link
	logic [DIV_INT_W-1:0] div_int; // programmed integer divisor
	logic [DIV_FRAC_W-1:0] div_frac; // programmed fractional divisor
	logic overrun; // sticky overrun error
	logic err_break; // break of last read character
	logic err_parity; // parity of last read character
	logic err_frame; // framing of last read character
	logic [7:0] line_flags; // registered flag word
	rx_state_e rx_state; // receiver sequence
	logic [3:0] os_cnt; // oversample tick counter
	logic [2:0] bit_idx; // data bit being received
	logic [DATA_W-1:0] shift; // received data bits
	logic par_bit; // received parity bit
	logic [ENTRY_W-1:0] rx_mem [FIFO_DEPTH]; // receive fifo storage
	logic [PTR_W-1:0] rx_wr; // receive write pointer
	logic [PTR_W-1:0] rx_rd; // receive read pointer
	logic [CNT_W-1:0] rx_cnt; // receive fill level
	logic [CNT_W-1:0] tx_cnt; // transmit fill level
	logic [CNT_W-1:0] cap; // capacity in the current mode
	logic push; // a character is finished this cycle
	logic [ENTRY_W-1:0] push_entry; // data and flags to store
	logic stored; // push found room
	logic popped; // data register read took a character
	logic tx_in; // transmit push accepted
	logic tx_out; // transmit pop accepted
	logic sample; // tick at the sampling point of a bit
	logic expect_par; // parity the settings ask for
	logic is_break; // whole frame was low
	logic access; // apb access phase awaiting answer
	logic do_write; // apb write completes this edge
	logic err_clear; // write to the error status register

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	baud_tick_gen u_tick (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.baud(baud)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode; answer comes one cycle into the access phase
	assign access = psel_i && penable_i && !pready_o;
	assign do_write = psel_i && penable_i && pready_o && pwrite_i;
	assign err_clear = do_write && (paddr_i == OFS_RX_ERR);

	// read mux and ready; unmapped addresses answer with an error
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (access) begin
			pready_o <= 1'b1;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			case (paddr_i)
				OFS_RX_ERR: begin
					prdata_o[BIT_OVERRUN] <= overrun;
					prdata_o[BIT_BREAK] <= err_break;
					prdata_o[BIT_PARITY] <= err_parity;
					prdata_o[BIT_FRAME] <= err_frame;
				end
				OFS_FLAGS: begin
					prdata_o[7:0] <= line_flags;
				end
				OFS_IR_DUMMY: begin
					prdata_o <= 32'h0000_0000;
				end
				OFS_DIV_INT: begin
					prdata_o[DIV_INT_W-1:0] <= div_int;
				end
				OFS_DIV_FRAC: begin
					prdata_o[DIV_FRAC_W-1:0] <= div_frac;
				end
				default: begin
					pslverr_o <= 1'b1; // nothing mapped here
				end
			endcase
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// divisor registers; the dummy infrared word keeps no state at all
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			div_int <= DIV_INT_RESET;
			div_frac <= DIV_FRAC_RESET;
		end else if (do_write && paddr_i == OFS_DIV_INT) begin
			div_int <= pwdata_i[DIV_INT_W-1:0];
		end else if (do_write && paddr_i == OFS_DIV_FRAC) begin
			div_frac <= pwdata_i[DIV_FRAC_W-1:0];
		end
	end

	// the running rate only changes between characters, so a frame in
	// flight is never stretched; a long stream delays the update
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			baud.divisor_int <= DIV_INT_RESET;
			baud.divisor_frac <= DIV_FRAC_RESET;
		end else if (rx_state == RX_IDLE && !tx_shift_busy_i) begin
			baud.divisor_int <= div_int;
			baud.divisor_frac <= div_frac;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receiver: sixteen ticks per bit, sampled mid-bit
	assign sample = baud.tick && (os_cnt == SAMPLE_LAST);
	// stick parity sends the inverse of even select, else true parity
	assign expect_par = stick_parity_select_i ? !even_parity_select_i :
		(even_parity_select_i ? ^shift : !(^shift));
	// all bits low through the stop slot means a break, not a character
	assign is_break = !rxd_i && (shift == '0) &&
		(!parity_enable_i || !par_bit);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= RX_IDLE;
			os_cnt <= 4'h0;
			bit_idx <= 3'h0;
			shift <= '0;
			par_bit <= 1'b0;
		end else if (baud.tick) begin
			os_cnt <= os_cnt + 4'h1;
			case (rx_state)
				RX_IDLE: begin
					if (!rxd_i) begin // possible start edge
						rx_state <= RX_START;
						os_cnt <= 4'h0;
					end
				end
				RX_START: begin
					if (os_cnt == SAMPLE_MID) begin
						// a glitch shorter than half a bit is dropped
						rx_state <= rxd_i ? RX_IDLE : RX_DATA;
						os_cnt <= 4'h0;
						bit_idx <= 3'h0;
						par_bit <= 1'b0;
					end
				end
				RX_DATA: begin
					if (sample) begin
						shift <= {rxd_i, shift[DATA_W-1:1]}; // lsb first
						bit_idx <= bit_idx + 3'h1;
						if (bit_idx == LAST_DATA_BIT) begin
							rx_state <= parity_enable_i ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (sample) begin
						par_bit <= rxd_i;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (sample) begin
						// after a break no new character until the line idles
						rx_state <= is_break ? RX_WAIT_HIGH : RX_IDLE;
					end
				end
				RX_WAIT_HIGH: begin
					if (rxd_i) begin
						rx_state <= RX_IDLE;
					end
				end
				default: begin
					rx_state <= RX_IDLE;
				end
			endcase
		end
	end

	// a finished frame becomes one fifo entry; a break stores one zero
	assign push = sample && (rx_state == RX_STOP);
	always_comb begin
		push_entry = '0;
		if (is_break) begin
			push_entry[BIT_BREAK] = 1'b1;
		end else begin
			push_entry[ENTRY_W-1:3] = shift;
			push_entry[BIT_PARITY] = parity_enable_i && (par_bit != expect_par);
			push_entry[BIT_FRAME] = !rxd_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive fifo; character mode limits it to one holding entry
	assign cap = fifo_enable_i ? FIFO_CAP : CHAR_CAP;
	assign stored = push && (rx_cnt < cap);
	assign popped = data_read_i && (rx_cnt != '0);

	always_ff @(posedge clk_sys_i) begin
		if (stored) begin
			rx_mem[rx_wr] <= push_entry;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_wr <= '0;
			rx_rd <= '0;
			rx_cnt <= '0;
		end else begin
			rx_wr <= rx_wr + PTR_W'(stored);
			rx_rd <= rx_rd + PTR_W'(popped);
			rx_cnt <= rx_cnt + CNT_W'(stored) - CNT_W'(popped);
		end
	end

	// the read takes the head entry, its flags replace the status
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_o <= '0;
			rx_char_valid_o <= 1'b0;
			err_break <= 1'b0;
			err_parity <= 1'b0;
			err_frame <= 1'b0;
		end else if (popped) begin
			rx_data_o <= rx_mem[rx_rd][ENTRY_W-1:3];
			rx_char_valid_o <= 1'b1;
			err_break <= rx_mem[rx_rd][BIT_BREAK];
			err_parity <= rx_mem[rx_rd][BIT_PARITY];
			err_frame <= rx_mem[rx_rd][BIT_FRAME];
		end else begin
			rx_char_valid_o <= 1'b0;
			if (err_clear) begin
				err_break <= 1'b0;
				err_parity <= 1'b0;
				err_frame <= 1'b0;
			end
		end
	end

	// overrun rises on the dropped frame itself; set beats any clear
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			overrun <= 1'b0;
		end else if (push && !stored) begin
			overrun <= 1'b1;
		end else if (stored || err_clear) begin
			overrun <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit occupancy; the data itself lives with the shifter
	assign tx_in = tx_write_i && (tx_cnt < cap);
	assign tx_out = tx_pop_i && (tx_cnt != '0);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt <= '0;
		end else begin
			tx_cnt <= tx_cnt + CNT_W'(tx_in) - CNT_W'(tx_out);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag word registered from the fill levels, so it trails them by one cycle
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			line_flags <= 8'h00;
			line_flags[BIT_TX_EMPTY] <= 1'b1;
			line_flags[BIT_RX_EMPTY] <= 1'b1;
			rx_empty_o <= 1'b1;
			tx_full_o <= 1'b0;
		end else begin
			line_flags <= 8'h00;
			line_flags[BIT_TX_EMPTY] <= (tx_cnt == '0);
			line_flags[BIT_RX_FULL] <= (rx_cnt >= cap);
			line_flags[BIT_TX_FULL] <= (tx_cnt >= cap);
			line_flags[BIT_RX_EMPTY] <= (rx_cnt == '0);
			// busy ignores the enable and covers the last stop bit
			line_flags[BIT_BUSY] <= (tx_cnt != '0) || tx_shift_busy_i;
			line_flags[BIT_CTS] <= !clear_to_send_n_input_i;
			rx_empty_o <= (rx_cnt == '0);
			tx_full_o <= (tx_cnt >= cap);
		end
	end
endmodule // uart_status_flags

// ---- uart_status_flags_bench.sv ----
// self-checking bench for the uart status, flag and divisor block
`timescale 1ns/1ns
module uart_status_flags_bench;
	import uart_status_pkg::*;
	logic clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rxd_i, err;
	logic cts_n, fifo_enable, pen, even_parity_select, stick_parity_select, data_read_i, tx_write_i, tx_pop_i, shift_busy;
	logic rx_char_valid_o, rx_empty_o, tx_full_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [7:0] rx_data_o;
	int n_mismatch = 0;
	int samples_checked = 0;
	uart_status_flags u_uart_status_flags (.clk_sys_i, .reset_n_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i,
		.clear_to_send_n_input_i(cts_n), .fifo_enable_i(fifo_enable), .parity_enable_i(pen),
		.even_parity_select_i(even_parity_select), .stick_parity_select_i(stick_parity_select), .data_read_i, .tx_write_i,
		.tx_pop_i, .tx_shift_busy_i(shift_busy), .rx_data_o, .rx_char_valid_o, .rx_empty_o,
		.tx_full_o);
	serial_peer_model u_serial_peer_model (.clk_i(clk_sys_i), .rxd_o(rxd_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	//////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		// no wait count is assumed; only the watchdog ends a hung transfer
		do begin
			@(posedge clk_sys_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	// flag word from tx empty, rx full, tx full, rx empty, busy
	function automatic logic [31:0] flg(input logic [4:0] v);
		return {24'h0, v, 3'h0};
	endfunction
	// single-cycle strobes with a gap: 0 push, 1 shifter take, 2 data read
	task automatic strobe(input int k, input int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			case (k)
				0: tx_write_i <= 1'b1;
				1: tx_pop_i <= 1'b1;
				default: data_read_i <= 1'b1;
			endcase
			@(posedge clk_sys_i);
			{tx_write_i, tx_pop_i, data_read_i} <= 3'h0;
		end
		@(posedge clk_sys_i);
	endtask
	task automatic t_registers;
		rchk("status reset", OFS_RX_ERR, 32'hF, 32'h0);
		rchk("flags reset", OFS_FLAGS, 32'hFF, flg(5'b10010));
		rchk("int reset", OFS_DIV_INT, 32'hFFFFFFFF, 32'h0);
		rchk("frac reset", OFS_DIV_FRAC, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, OFS_DIV_INT, 32'hFFFFFFFF);
		rchk("int field", OFS_DIV_INT, 32'hFFFFFFFF, 32'h0000FFFF);
		apb(1'b1, OFS_DIV_FRAC, 32'hFFFFFFFF);
		rchk("frac field", OFS_DIV_FRAC, 32'hFFFFFFFF, 32'h3F);
		apb(1'b1, OFS_IR_DUMMY, 32'hA5A5A5A5);
		rchk("infrared", OFS_IR_DUMMY, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, OFS_DIV_INT, 32'h1); // sixteen clocks per bit from here on
		apb(1'b1, OFS_DIV_FRAC, 32'h0);
		cts_n <= 1'b0;
		rchk("cts", OFS_FLAGS, 32'h7, 32'h1);
		$display("test registers done");
	endtask
	task automatic t_transmit;
		fifo_enable <= 1'b0;
		strobe(0, 1);
		rchk("holding flags", OFS_FLAGS, 32'hF8, flg(5'b00111));
		shift_busy <= 1'b1;
		strobe(1, 1);
		rchk("shift flags", OFS_FLAGS, 32'hF8, flg(5'b10011));
		shift_busy <= 1'b0;
		fifo_enable <= 1'b1;
		strobe(0, 17); // the last push must be refused
		rchk("fifo full", OFS_FLAGS, 32'hF8, flg(5'b00111));
		chk("tx full pin", 32'h1, {31'h0, tx_full_o});
		strobe(1, 15);
		rchk("one left", OFS_FLAGS, 32'hF8, flg(5'b00011));
		strobe(1, 1);
		rchk("drained", OFS_FLAGS, 32'hF8, flg(5'b10010));
		$display("test transmit flags done");
	endtask
	task automatic t_rx_errors;
		logic [7:0] dat [5] = '{8'hA5, 8'h3C, 8'h01, 8'h0F, 8'h81};
		logic [31:0] es [5] = '{32'h0, 32'h2, 32'h0, 32'h2, 32'h1};
		logic [4:0] ev = 5'b10011;
		logic [4:0] st = 5'b11000;
		logic [4:0] pb = 5'b00010;
		logic [4:0] sp = 5'b01111;
		int i;
		pen <= 1'b1;
		for (i = 0; i < 5; i++) begin
			even_parity_select <= ev[i];
			stick_parity_select <= st[i];
			u_serial_peer_model.send_frame(dat[i], 1'b1, pb[i], sp[i]);
		end
		for (i = 0; i < 5; i++) begin
			strobe(2, 1); // data first, then its status
			chk("char", {24'h0, dat[i]}, {24'h0, rx_data_o});
			rchk("char status", OFS_RX_ERR, 32'hF, es[i]);
		end
		rchk("rx drained", OFS_FLAGS, 32'h10, 32'h10);
		$display("test receive errors done");
	endtask
	task automatic t_break;
		pen <= 1'b0;
		u_serial_peer_model.hold_low(20);
		strobe(2, 1);
		chk("break char", 32'h0, {24'h0, rx_data_o});
		rchk("break status", OFS_RX_ERR, 32'h4, 32'h4);
		rchk("one break entry", OFS_FLAGS, 32'h10, 32'h10);
		apb(1'b1, OFS_RX_ERR, 32'h0);
		rchk("cleared", OFS_RX_ERR, 32'hF, 32'h0);
		$display("test break done");
	endtask
	task automatic t_overrun;
		fifo_enable <= 1'b0;
		u_serial_peer_model.send_frame(8'h5A, 1'b0, 1'b0, 1'b1);
		rchk("holding full", OFS_FLAGS, 32'h50, 32'h40);
		chk("rx empty pin", 32'h0, {31'h0, rx_empty_o});
		rchk("no overrun", OFS_RX_ERR, 32'h8, 32'h0);
		u_serial_peer_model.send_frame(8'hC3, 1'b0, 1'b0, 1'b1);
		rchk("overrun", OFS_RX_ERR, 32'h8, 32'h8);
		strobe(2, 1);
		chk("kept char", 32'h5A, {24'h0, rx_data_o});
		fork
			u_serial_peer_model.send_frame(8'h3C, 1'b0, 1'b0, 1'b1);
			begin // a slow rate written mid-frame must not reach this frame
				repeat (40) @(posedge clk_sys_i);
				apb(1'b1, OFS_DIV_INT, 32'h10);
				repeat (64) @(posedge clk_sys_i);
				apb(1'b1, OFS_DIV_INT, 32'h1);
			end
		join
		rchk("overrun gone", OFS_RX_ERR, 32'h8, 32'h0);
		strobe(2, 2); // second pop finds nothing
		chk("empty pop", 32'h3C, {24'h0, rx_data_o});
		$display("test overrun done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// watchdog: the whole run needs well under twenty thousand clocks
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		n_mismatch++;
		complete_run();
	end
	initial begin
		{reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		{fifo_enable, pen, even_parity_select, stick_parity_select, data_read_i, tx_write_i, tx_pop_i, shift_busy} = '0;
		cts_n = 1'b1;
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_registers();
		t_transmit();
		t_rx_errors();
		t_break();
		t_overrun();
		complete_run();
	end
endmodule // uart_status_flags_bench
bind uart_status_flags uart_status_flags_monitor u_uart_status_flags_monitor (.clk_sys_i,
	.reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
	.pslverr_o, .rxd_i, .clear_to_send_n_input_i, .fifo_enable_i, .parity_enable_i,
	.even_parity_select_i, .stick_parity_select_i, .data_read_i, .tx_write_i, .tx_pop_i,
	.tx_shift_busy_i, .rx_data_o, .rx_char_valid_o, .rx_empty_o, .tx_full_o);

// ---- uart_status_flags_monitor.sv ----
// port-level assertions for the uart status, flag and divisor block
`timescale 1ns/1ns
module uart_status_flags_monitor
	import uart_status_pkg::*;
(
	input wire logic clk_sys_i, // clock
	input wire logic reset_n_i, // reset, low
	input wire logic psel_i, // select
	input wire logic penable_i, // access
	input wire logic pwrite_i, // write
	input wire logic [11:0] paddr_i, // address
	input wire logic [31:0] pwdata_i, // write data
	input wire logic [31:0] prdata_o, // read data
	input wire logic pready_o, // ready
	input wire logic pslverr_o, // error
	input wire logic rxd_i, // line
	input wire logic clear_to_send_n_input_i, // cts, low
	input wire logic fifo_enable_i, // fifo mode
	input wire logic parity_enable_i, // parity on
	input wire logic even_parity_select_i, // even
	input wire logic stick_parity_select_i, // stick
	input wire logic data_read_i, // pop
	input wire logic tx_write_i, // push
	input wire logic tx_pop_i, // shifter take
	input wire logic tx_shift_busy_i, // shifting
	input wire logic [DATA_W-1:0] rx_data_o, // char
	input wire logic rx_char_valid_o, // char pulse
	input wire logic rx_empty_o, // rx empty
	input wire logic tx_full_o // tx full
);
	// first access edge of a transfer, where the answer is launched
	wire logic acc = psel_i && penable_i && !pready_o;
	wire logic rd_acc = acc && !pwrite_i; // reads only
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	//////////////////////////////
	a_ready_pulse: assert property (acc |=> pready_o ##1 !pready_o)
		else $error("ready is not one pulse after the access edge");
	a_error_ready: assert property (pslverr_o |-> pready_o)
		else $error("error shown without ready");
	a_flag_cts: assert property (rd_acc && paddr_i == OFS_FLAGS |=>
		prdata_o[BIT_CTS] == !$past(clear_to_send_n_input_i, 2) && prdata_o[8] == 1'b0)
		else $error("clear to send bit wrong");
	a_ir_zero: assert property (rd_acc && paddr_i == OFS_IR_DUMMY |=> prdata_o == 32'h0)
		else $error("infrared word not zero");
	a_int_width: assert property (rd_acc && paddr_i == OFS_DIV_INT |=> prdata_o[31:16] == 16'h0)
		else $error("integer divisor wider than sixteen bits");
	a_frac_width: assert property (rd_acc && paddr_i == OFS_DIV_FRAC |=> prdata_o[31:6] == 26'h0)
		else $error("fraction divisor wider than six bits");
	// the empty pin one cycle after a read reflects the fill level that the read saw
	a_char_from_pop: assert property (rx_char_valid_o |-> $past(data_read_i) && !rx_empty_o)
		else $error("character refreshed without a pop");
	a_char_held: assert property (!rx_char_valid_o |-> $stable(rx_data_o))
		else $error("character changed without a pop");
	a_empty_no_char: assert property (data_read_i |=> rx_char_valid_o == !rx_empty_o)
		else $error("pop result disagrees with the receive empty flag");
	a_hold_full: assert property (!fifo_enable_i && tx_write_i && !tx_full_o && !tx_pop_i
		|-> ##[1:2] tx_full_o)
		else $error("holding register not full after a push");
endmodule // uart_status_flags_monitor

// ---- uart_status_pkg.sv ----
// constants, register map and state type shared by the uart status block
package uart_status_pkg;
	// register byte offsets on the apb bus
	localparam logic [11:0] OFS_RX_ERR = 12'h000;
	localparam logic [11:0] OFS_FLAGS = 12'h004;
	localparam logic [11:0] OFS_IR_DUMMY = 12'h008;
	localparam logic [11:0] OFS_DIV_INT = 12'h00C;
	localparam logic [11:0] OFS_DIV_FRAC = 12'h010;
	// receive error status bit positions
	localparam int BIT_OVERRUN = 3;
	localparam int BIT_BREAK = 2;
	localparam int BIT_PARITY = 1;
	localparam int BIT_FRAME = 0;
	// line flag bit positions
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL = 6;
	localparam int BIT_TX_FULL = 5;
	localparam int BIT_RX_EMPTY = 4;
	localparam int BIT_BUSY = 3;
	localparam int BIT_CTS = 0;
	// field widths and reset values
	localparam int DIV_INT_W = 16;
	localparam int DIV_FRAC_W = 6;
	localparam logic [15:0] DIV_INT_RESET = 16'h0000;
	localparam logic [5:0] DIV_FRAC_RESET = 6'h00;
	localparam int DATA_W = 8;
	// fifo geometry: entry = data, break, parity, frame
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int ENTRY_W = 11;
	localparam logic [4:0] FIFO_CAP = 5'h10;
	localparam logic [4:0] CHAR_CAP = 5'h01;
	// oversampling: sixteen ticks per bit, mid-bit at seven
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'hF;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;
	// fractional accumulator step: one clock equals sixty-four 64ths
	localparam int ACC_W = 23;
	localparam logic [22:0] FRAC_ONE = 23'h000040;
	// receiver states, gray coded along the frame
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h3,
		RX_PARITY = 3'h2,
		RX_STOP = 3'h6,
		RX_WAIT_HIGH = 3'h7
	} rx_state_e;
endpackage
